// ===== design/bcd_sum_adjust_unit.sv
// decimal adjust after byte addition, sequenced over eight clocks
`timescale 1ns/1ps
`default_nettype none
module bcd_sum_adjust_unit
    import bsau_pkg::*;
(
    // clock, reset, enable
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       clk_en_i,
    // request from the sequencer
    input  wire logic       start_i,
    input  wire logic [7:0] opcode_i,
    input  wire logic [7:0] accum_low_byte_i,
    input  wire logic [7:0] accum_high_byte_i,
    input  wire logic       carry_flag_i,
    input  wire logic       aux_carry_flag_i,
    // answer
    output logic            busy_o,
    output logic            done_o,
    output logic      [7:0] accum_low_byte_o,
    output logic      [7:0] accum_high_byte_o,
    output logic            carry_flag_o,
    output logic            aux_carry_flag_o
);
    bsau_state_t state;
    bsau_state_t next_state;
    logic [2:0]  count;
    logic [7:0]  low_in;
    logic [7:0]  high_in;
    logic        aux_in;
    logic [7:0]  low_fix;
    logic [7:0]  high_fix;
    logic        dec_carry;
    logic        accept;

    // =========================================================
    // request decode
    assign accept = clk_en_i && start_i && (state == BSAU_IDLE)
                 && (opcode_i == BSAU_OPCODE);
    assign busy_o = (state == BSAU_BUSY);
    assign done_o = (state == BSAU_DONE);

    bsau_digit_fix u_fix (
        .accum_low_byte_i  (low_in),
        .accum_high_byte_i (high_in),
        .aux_carry_flag_i  (aux_in),
        .low_result_o      (low_fix),
        .high_result_o     (high_fix),
        .decimal_carry_o   (dec_carry)
    );

    // =========================================================
    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            BSAU_IDLE: if (accept) next_state = BSAU_BUSY;
            BSAU_BUSY: if (count == BSAU_LAST_COUNT - BSAU_COUNT_STEP) next_state = BSAU_DONE;
            BSAU_DONE: next_state = BSAU_IDLE;
            default:   next_state = BSAU_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state <= BSAU_IDLE;
        end else if (clk_en_i) begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            count <= BSAU_COUNT_ZERO;
        end else if (clk_en_i) begin
            if (accept) begin
                count <= BSAU_COUNT_ZERO;
            end else if (state == BSAU_BUSY) begin
                count <= count + BSAU_COUNT_STEP;
            end
        end
    end

    // =========================================================
    // operand capture, aux carry flag consumed from the preceding addition
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            low_in  <= BSAU_BYTE_RESET;
            high_in <= BSAU_BYTE_RESET;
            aux_in  <= 1'b0;
        end else if (accept) begin
            low_in  <= accum_low_byte_i;
            high_in <= accum_high_byte_i;
            aux_in  <= aux_carry_flag_i;
        end
    end

    // =========================================================
    // results, written on the last busy clock
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            accum_low_byte_o  <= BSAU_BYTE_RESET;
            accum_high_byte_o <= BSAU_BYTE_RESET;
            carry_flag_o      <= 1'b0;
            aux_carry_flag_o  <= 1'b0;
        end else if (clk_en_i && state == BSAU_BUSY
                     && count == BSAU_LAST_COUNT - BSAU_COUNT_STEP) begin
            accum_low_byte_o  <= low_fix;
            accum_high_byte_o <= high_fix;
            carry_flag_o      <= dec_carry;
            aux_carry_flag_o  <= dec_carry;
        end
    end

    // sign, zero, parity, overflow have no port here, so stay untouched

    // =========================================================
    // checks
    sequence s_start;
        accept;
    endsequence

    // request taken, seven busy clocks, one done clock
    sequence s_run;
        busy_o [*7] ##1 done_o;
    endsequence

    sequence s_release;
        !busy_o && !done_o;
    endsequence

    property p_latency;
        @(posedge mclk_i) disable iff (reset_i || !clk_en_i)
            s_start |=> s_run;
    endproperty

    property p_done_release;
        @(posedge mclk_i) disable iff (reset_i || !clk_en_i)
            done_o |=> s_release;
    endproperty

    a_exec_latency: assert property (p_latency)
        else $error("adjust did not finish in eight clocks");

    a_done_release: assert property (p_done_release)
        else $error("done did not return to idle after one clock");

    a_high_nibble_zero: assert property (
        @(posedge mclk_i) disable iff (reset_i) done_o |-> accum_low_byte_o[7:4] == 4'h0)
        else $error("upper nibble of low byte not cleared");

    a_flags_equal: assert property (
        @(posedge mclk_i) disable iff (reset_i) done_o |-> carry_flag_o == aux_carry_flag_o)
        else $error("carry and aux carry differ after adjust");

    a_carry_high_inc: assert property (
        @(posedge mclk_i) disable iff (reset_i)
            (done_o && carry_flag_o) |-> accum_high_byte_o == high_in + BSAU_HIGH_STEP)
        else $error("high byte not incremented on decimal carry");

    a_nocarry_high_keep: assert property (
        @(posedge mclk_i) disable iff (reset_i)
            (done_o && !carry_flag_o) |-> accum_high_byte_o == high_in)
        else $error("high byte changed without decimal carry");

    a_trigger_cond: assert property (
        @(posedge mclk_i) disable iff (reset_i)
            done_o |-> carry_flag_o == ((low_in[3:0] > BSAU_DIGIT_MAX) || aux_in))
        else $error("correction trigger wrong");

    a_aux_trigger: assert property (
        @(posedge mclk_i) disable iff (reset_i) (done_o && aux_in) |-> carry_flag_o)
        else $error("incoming aux carry did not trigger correction");

    a_fix_value: assert property (
        @(posedge mclk_i) disable iff (reset_i) (done_o && carry_flag_o)
            |-> accum_low_byte_o == ((low_in + {4'h0, BSAU_DIGIT_FIX}) & BSAU_NIBBLE_MASK))
        else $error("corrected digit wrong");

    a_nofix_value: assert property (
        @(posedge mclk_i) disable iff (reset_i) (done_o && !carry_flag_o)
            |-> accum_low_byte_o == (low_in & BSAU_NIBBLE_MASK))
        else $error("uncorrected digit wrong");

    a_hold_results: assert property (
        @(posedge mclk_i) disable iff (reset_i)
            (state == BSAU_IDLE && $past(state) == BSAU_IDLE && !$past(reset_i))
            |-> $stable(accum_high_byte_o) && $stable(carry_flag_o)
                && $stable(accum_low_byte_o) && $stable(aux_carry_flag_o))
        else $error("outputs changed while idle");

    a_done_after_busy: assert property (
        @(posedge mclk_i) disable iff (reset_i) (done_o && $past(clk_en_i)) |-> $past(busy_o))
        else $error("done raised without a busy clock before it");

    a_wrong_opcode: assert property (
        @(posedge mclk_i) disable iff (reset_i)
            (state == BSAU_IDLE && start_i && opcode_i != BSAU_OPCODE) |=> s_release)
        else $error("request with another opcode was taken");

    // clock enable low holds every register
    a_enable_freeze: assert property (
        @(posedge mclk_i) disable iff (reset_i)
            !clk_en_i |=> state == $past(state) && count == $past(count)
                && $stable(accum_low_byte_o))
        else $error("state moved while the clock enable was low");

    a_operand_capture: assert property (
        @(posedge mclk_i) disable iff (reset_i)
            s_start |=> aux_in == $past(aux_carry_flag_i) && low_in == $past(accum_low_byte_i)
                && high_in == $past(accum_high_byte_i))
        else $error("operands not captured at the taking edge");

    a_reset_values: assert property (
        @(posedge mclk_i) reset_i |=> !busy_o && !done_o && !carry_flag_o
            && accum_low_byte_o == BSAU_BYTE_RESET && accum_high_byte_o == BSAU_BYTE_RESET)
        else $error("outputs not cleared by reset");
endmodule : bcd_sum_adjust_unit
`default_nettype wire

// ===== common/bsau_pkg.sv
// constants and types shared by the decimal sum adjust unit
package bsau_pkg;
    localparam logic [7:0] BSAU_OPCODE      = 8'h37;
    localparam int         BSAU_EXEC_CLKS   = 8;
    localparam logic [2:0] BSAU_LAST_COUNT  = 3'(BSAU_EXEC_CLKS - 1);
    localparam logic [3:0] BSAU_DIGIT_MAX   = 4'h9;
    localparam logic [3:0] BSAU_DIGIT_FIX   = 4'h6;
    localparam logic [7:0] BSAU_NIBBLE_MASK = 8'h0f;
    localparam logic [7:0] BSAU_HIGH_STEP   = 8'h01;
    localparam logic [7:0] BSAU_BYTE_RESET  = 8'h00;
    localparam logic [2:0] BSAU_COUNT_ZERO  = 3'h0;
    localparam logic [2:0] BSAU_COUNT_STEP  = 3'h1;

    typedef enum logic [1:0] {
        BSAU_IDLE = 2'b00,
        BSAU_BUSY = 2'b01,
        BSAU_DONE = 2'b10
    } bsau_state_t;
endpackage : bsau_pkg

// ===== design/bsau_digit_fix.sv
// combinational digit correction for the decimal sum adjust
`timescale 1ns/1ps
`default_nettype none
module bsau_digit_fix
    import bsau_pkg::*;
(
    // operands
    input  wire logic [7:0] accum_low_byte_i,
    input  wire logic [7:0] accum_high_byte_i,
    input  wire logic       aux_carry_flag_i,
    // results
    output logic      [7:0] low_result_o,
    output logic      [7:0] high_result_o,
    output logic            decimal_carry_o
);
    logic [3:0] digit;

    assign digit           = accum_low_byte_i[3:0];
    // incoming aux carry is one of the two triggers
    assign decimal_carry_o = (digit > BSAU_DIGIT_MAX) || aux_carry_flag_i;
    // upper nibble is always forced to zero
    assign low_result_o    = decimal_carry_o
                           ? ({4'h0, digit} + {4'h0, BSAU_DIGIT_FIX}) & BSAU_NIBBLE_MASK
                           : {4'h0, digit};
    assign high_result_o   = decimal_carry_o
                           ? accum_high_byte_i + BSAU_HIGH_STEP
                           : accum_high_byte_i;
endmodule : bsau_digit_fix
`default_nettype wire

// ===== dv/bsau_seq_model.sv
// sequencer model that issues decimal adjust requests after a byte add
`timescale 1ns/1ps
`default_nettype none
module bsau_seq_model
(
    // clock and answer
    input  wire logic       mclk_i,
    input  wire logic       done_i,
    // request
    output logic            start_o,
    output logic      [7:0] opcode_o,
    output logic      [7:0] low_o,
    output logic      [7:0] high_o,
    output logic            carry_o,
    output logic            aux_o
);
    initial begin
        start_o = 1'b0;
        opcode_o = 8'h00;
        {low_o, high_o, carry_o, aux_o} = 18'h0;
    end
    // add two digits, then request the adjust with the sum and its aux carry
    task automatic issue(input logic [7:0] op, a, b, hi, output int lat);
        @(negedge mclk_i);
        start_o = 1'b1;
        opcode_o = op;
        low_o = a + b;
        aux_o = (5'(a[3:0]) + 5'(b[3:0])) > 5'h0f;
        high_o = hi;
        carry_o = ~carry_o;
        @(negedge mclk_i);
        start_o = 1'b0;
        low_o = ~low_o;
        aux_o = ~aux_o;
        lat = 1;
        while (done_i !== 1'b1 && lat < 20) begin
            @(negedge mclk_i);
            lat++;
        end
    endtask : issue
endmodule : bsau_seq_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the decimal sum adjust unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bsau_pkg::*;
    logic       mclk_i, reset_i, clk_en_i, start, done, busy, carry_flag, aux_carry_flag;
    logic       carry_flag_in, aux_carry_flag_in;
    logic [7:0] op, lo, hi, lo_o, hi_o;
    int         err_count = 0, tests_run = 0, cycles = 0, lat;
    bcd_sum_adjust_unit u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .start_i(start), .opcode_i(op), .accum_low_byte_i(lo), .accum_high_byte_i(hi),
        .carry_flag_i(carry_flag_in), .aux_carry_flag_i(aux_carry_flag_in), .busy_o(busy),
        .done_o(done), .accum_low_byte_o(lo_o), .accum_high_byte_o(hi_o),
        .carry_flag_o(carry_flag), .aux_carry_flag_o(aux_carry_flag));
    bsau_seq_model u_seq (.mclk_i(mclk_i), .done_i(done), .start_o(start), .opcode_o(op),
        .low_o(lo), .high_o(hi), .carry_o(carry_flag_in), .aux_o(aux_carry_flag_in));
    task automatic check(input string name, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // digit sums around the correction boundary, high byte wrapping
    task automatic t_table();
        logic [7:0] a[5] = '{8'h05, 8'h09, 8'h02, 8'h09, 8'h08};
        logic [7:0] b[5] = '{8'h07, 8'h09, 8'h03, 8'h01, 8'h01};
        logic [7:0] h[5] = '{8'h00, 8'hff, 8'h12, 8'h34, 8'h41};
        logic [7:0] s;
        logic       fx;
        for (int i = 0; i < 5; i++) begin
            u_seq.issue(BSAU_OPCODE, a[i], b[i], h[i], lat);
            s = a[i] + b[i];
            fx = (s[3:0] > 4'h9) || (s > 8'h0f);
            check("latency", 8'(lat), 8'(BSAU_EXEC_CLKS));
            check("low", lo_o, fx ? ((s + 8'h06) & 8'h0f) : (s & 8'h0f));
            check("high", hi_o, h[i] + 8'(fx));
            check("flags", {6'h0, carry_flag, aux_carry_flag}, {6'h0, fx, fx});
        end
        $display("test table done");
    endtask : t_table
    // another opcode is ignored and the results stand
    task automatic t_refuse();
        u_seq.issue(8'h3f, 8'h05, 8'h07, 8'h00, lat);
        check("no done", 8'(lat), 8'd20);
        check("kept low", lo_o, 8'h09);
        check("kept high", hi_o, 8'h41);
        check("kept flags", {6'h0, carry_flag, aux_carry_flag}, 8'h00);
        check("busy", {7'h0, busy}, 8'h00);
        $display("test refuse done");
    endtask : t_refuse
    // three disabled cycles stretch the run to eleven
    task automatic t_enable();
        fork
            u_seq.issue(BSAU_OPCODE, 8'h06, 8'h06, 8'h07, lat);
            begin
                repeat (3) @(negedge mclk_i);
                clk_en_i = 1'b0;
                repeat (3) @(negedge mclk_i);
                clk_en_i = 1'b1;
            end
        join
        check("stretch", 8'(lat), 8'(BSAU_EXEC_CLKS + 3));
        check("low", lo_o, 8'h02);
        check("high", hi_o, 8'h08);
        check("flags", {6'h0, carry_flag, aux_carry_flag}, 8'h03);
        $display("test enable done");
    endtask : t_enable
    // reset while idle clears the results, then a request is taken again
    task automatic t_reset();
        @(negedge mclk_i);
        reset_i = 1'b1;
        @(negedge mclk_i);
        reset_i = 1'b0;
        check("reset low", lo_o, 8'h00);
        check("reset high", hi_o, 8'h00);
        check("reset flags", {6'h0, carry_flag, aux_carry_flag}, 8'h00);
        u_seq.issue(BSAU_OPCODE, 8'h04, 8'h03, 8'h20, lat);
        check("after reset low", lo_o, 8'h07);
        check("after reset high", hi_o, 8'h20);
        $display("test reset done");
    endtask : t_reset
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        reset_i = 1'b1;
        clk_en_i = 1'b1;
        repeat (5) @(negedge mclk_i);
        reset_i = 1'b0;
        t_table();
        t_refuse();
        t_enable();
        t_reset();
        complete_run();
    end
endmodule : tb
`default_nettype wire
